// ==== src/tuc_pkg.sv ====
package tuc_pkg;

    // ----------------------------------------------------------------
    // Clock rate and delay figures.
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned START_DELAY_US = 4700;
    localparam int unsigned MIN_CYCLE_US = 14000;
    localparam int unsigned REWIND_STOP_US = 1000000;
    localparam int unsigned MARKER_PULSE_US = 10;
    localparam int unsigned GAP_WINDOW_US = 1000;
    localparam int unsigned START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
    localparam int unsigned MIN_CYCLE_CYC = MIN_CYCLE_US * CLK_MHZ;
    localparam int unsigned REWIND_STOP_CYC = REWIND_STOP_US * CLK_MHZ;
    localparam int unsigned MARKER_PULSE_CYC = MARKER_PULSE_US * CLK_MHZ;
    localparam int unsigned GAP_WINDOW_CYC = GAP_WINDOW_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Widths and counter sizes.
    // ----------------------------------------------------------------
    localparam int unsigned UNIT_W = 3;
    localparam int unsigned TIMER_W = 28;
    localparam int unsigned PULSE_W = 12;

    // ----------------------------------------------------------------
    // Start command operation codes.
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_ERASE = 2'h1,
        OP_READ = 2'h2,
        OP_SCAN = 2'h3
    } tuc_op_t;

    // ----------------------------------------------------------------
    // Skip test selection codes.
    // ----------------------------------------------------------------
    typedef logic [3:0] tuc_skip_t;
    localparam tuc_skip_t SKIP_FILE_PROTECT = 4'h0;
    localparam tuc_skip_t SKIP_READY = 4'h1;
    localparam tuc_skip_t SKIP_LOAD_POINT = 4'h2;
    localparam tuc_skip_t SKIP_END_REEL = 4'h3;
    localparam tuc_skip_t SKIP_DENS_LOW = 4'h4;
    localparam tuc_skip_t SKIP_DENS_MID = 4'h5;
    localparam tuc_skip_t SKIP_DENS_HIGH = 4'h6;
    localparam tuc_skip_t SKIP_FILE_MARK = 4'h8;
    localparam tuc_skip_t SKIP_GAP = 4'h9;

    // ----------------------------------------------------------------
    // Motion sequencer states.
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_RUN = 4'h4,
        ST_GAP = 4'h8
    } tuc_state_t;

endpackage

// ==== src/tuc_timer_if.sv ====
`timescale 1ns/1ps
interface tuc_timer_if;
    logic start;
    logic busy;
    logic done;
    modport timer (input start, output busy, output done);
    modport user (output start, input busy, input done);
endinterface

// ==== src/tuc_sync.sv ====
`timescale 1ns/1ps
module tuc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            stage <= '0;
            synced <= '0;
        end
        else
        begin
            stage <= raw;
            synced <= stage;
        end
    end
endmodule // tuc_sync

// ==== src/tuc_timer.sv ====
`timescale 1ns/1ps
module tuc_timer #(
    parameter int WIDTH = 28,
    parameter logic [WIDTH-1:0] COUNT = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    tuc_timer_if.timer tmr
);
    logic [WIDTH-1:0] count;

    // Retriggerable: a start reloads the full count.
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            count <= '0;
        else if (tmr.start)
            count <= COUNT;
        else if (count != '0)
            count <= count - WIDTH'(1);
    end

    assign tmr.busy = (count != '0);
    assign tmr.done = (count == WIDTH'(1)) && !tmr.start;
endmodule // tuc_timer

// ==== src/tuc_top.sv ====
`timescale 1ns/1ps
module tuc_top #(
    parameter int NUM_UNITS = 8,
    parameter int unsigned START_DELAY_CYCLES = tuc_pkg::START_DELAY_CYC,
    parameter int unsigned MIN_CYCLE_CYCLES = tuc_pkg::MIN_CYCLE_CYC,
    parameter int unsigned REWIND_STOP_CYCLES = tuc_pkg::REWIND_STOP_CYC,
    parameter int unsigned GAP_WINDOW_CYCLES = tuc_pkg::GAP_WINDOW_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [NUM_UNITS-1:0] loadMarker,
    input wire logic [NUM_UNITS-1:0] endMarker,
    input wire logic [NUM_UNITS-1:0] transportReady,
    input wire logic [NUM_UNITS-1:0] autoMode,
    input wire logic [NUM_UNITS-1:0] fileProtect,
    input wire logic [NUM_UNITS-1:0][tuc_pkg::UNIT_W-1:0] unitSwitch,
    input wire logic [NUM_UNITS-1:0][2:0] densitySwitch,
    input wire logic testSwitch,
    input wire logic writeCharClock,
    input wire logic startCmd,
    input wire tuc_pkg::tuc_op_t startOp,
    input wire logic startBcd,
    input wire logic [tuc_pkg::UNIT_W-1:0] startUnit,
    input wire logic rewindCmd,
    input wire logic [tuc_pkg::UNIT_W-1:0] rewindUnit,
    input wire logic haltRequest,
    input wire logic continueCmd,
    input wire logic gapDetect,
    input wire logic notFileMark,
    input wire logic skipCmd,
    input wire tuc_pkg::tuc_skip_t skipCode,
    input wire logic [tuc_pkg::UNIT_W-1:0] skipUnit,
    output logic skipTestLine,
    output logic [NUM_UNITS-1:0] loadPoint,
    output logic [NUM_UNITS-1:0] endOfReel,
    output logic [NUM_UNITS-1:0] loadPointInterrupt,
    output logic [NUM_UNITS-1:0] endReelInterrupt,
    output logic [NUM_UNITS-1:0] unitSelect,
    output logic [NUM_UNITS-1:0] rewinding,
    output logic [NUM_UNITS-1:0] unitReady,
    output logic [NUM_UNITS-1:0] forwardActuate,
    output logic [NUM_UNITS-1:0] reverseActuate,
    output logic densityLowOut,
    output logic densityMidOut,
    output logic densityHighOut,
    output logic forwardRun,
    output logic bcdMode,
    output logic oddParity,
    output logic writeEnable,
    output logic startDelayBusy,
    output logic minCycleBusy,
    output logic haltSignal,
    output logic syncFlag,
    output logic writeClockDetect,
    output logic loadPointInhibit,
    output logic fileMarkFlag
);
    import tuc_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers.
    // ----------------------------------------------------------------
    localparam int PIN_W = NUM_UNITS * (5 + UNIT_W + 3) + 2;

    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] pinSync;
    logic [NUM_UNITS-1:0] lmS;
    logic [NUM_UNITS-1:0] emS;
    logic [NUM_UNITS-1:0] rdyS;
    logic [NUM_UNITS-1:0] autoS;
    logic [NUM_UNITS-1:0] fpS;
    logic [NUM_UNITS-1:0][UNIT_W-1:0] uswS;
    logic [NUM_UNITS-1:0][2:0] densS;
    logic testS;
    logic wclkS;

    assign pinRaw = {testSwitch, writeCharClock, loadMarker, endMarker, transportReady,
                     autoMode, fileProtect, unitSwitch, densitySwitch};
    assign {testS, wclkS, lmS, emS, rdyS, autoS, fpS, uswS, densS} = pinSync;

    tuc_sync #(.WIDTH(PIN_W)) uPinSync (
        .clk_sys(clk_sys),
        .reset(reset),
        .raw(pinRaw),
        .synced(pinSync)
    );

    // ----------------------------------------------------------------
    // Shared control timers.
    // ----------------------------------------------------------------
    tuc_timer_if startDelayIf ();
    tuc_timer_if minCycleIf ();
    tuc_timer_if gapWindowIf ();

    tuc_timer #(.WIDTH(TIMER_W), .COUNT(TIMER_W'(START_DELAY_CYCLES))) uStartDelay (
        .clk_sys(clk_sys),
        .reset(reset),
        .tmr(startDelayIf)
    );
    tuc_timer #(.WIDTH(TIMER_W), .COUNT(TIMER_W'(MIN_CYCLE_CYCLES))) uMinCycle (
        .clk_sys(clk_sys),
        .reset(reset),
        .tmr(minCycleIf)
    );
    tuc_timer #(.WIDTH(TIMER_W), .COUNT(TIMER_W'(GAP_WINDOW_CYCLES))) uGapWindow (
        .clk_sys(clk_sys),
        .reset(reset),
        .tmr(gapWindowIf)
    );

    // ----------------------------------------------------------------
    // Command decoding.
    // ----------------------------------------------------------------
    tuc_state_t state;
    tuc_state_t next_state;
    tuc_op_t opReg;
    logic continued;
    logic wclkPrev;
    logic stopPulse;
    logic gapTimeout;
    logic startFromRest;
    logic isWriteOp;
    logic wclkRise;
    logic anySelected;
    logic [NUM_UNITS-1:0] startAtLoadPoint;
    logic [NUM_UNITS-1:0] unitSkip;
    logic [NUM_UNITS-1:0] densLowU;
    logic [NUM_UNITS-1:0] densMidU;
    logic [NUM_UNITS-1:0] densHighU;
    logic skipAnswer;

    assign startFromRest = startCmd && !forwardRun;
    assign isWriteOp = (opReg == OP_WRITE) || (opReg == OP_ERASE);
    assign wclkRise = wclkS && !wclkPrev;
    assign anySelected = |unitSelect;
    assign gapTimeout = (state == ST_GAP) && gapWindowIf.done && !continueCmd;
    assign stopPulse = haltSignal || gapTimeout;

    assign startDelayIf.start = startFromRest;
    assign minCycleIf.start = startFromRest;
    assign gapWindowIf.start = (state == ST_RUN) && gapDetect;
    assign startDelayBusy = startDelayIf.busy;
    assign minCycleBusy = minCycleIf.busy;

    assign haltSignal = haltRequest && forwardRun && !startDelayIf.busy && !minCycleIf.busy
                        && !gapWindowIf.busy;

    assign writeEnable = forwardRun && isWriteOp && anySelected && !testS;
    assign oddParity = !bcdMode;

    // ----------------------------------------------------------------
    // Per-unit logic.
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++)
        begin : gUnit
            logic emPrev;
            logic addrStart;
            logic addrRewind;
            logic addrSkip;
            logic rwStopStart;
            logic eorEncounter;
            logic eorDetect;
            logic nextLoadPoint;
            logic nextEndReel;
            logic skipSel;
            tuc_timer_if rwStopIf ();
            tuc_timer_if markerIf ();

            tuc_timer #(.WIDTH(TIMER_W), .COUNT(TIMER_W'(REWIND_STOP_CYCLES))) uRewindStop (
                .clk_sys(clk_sys),
                .reset(reset),
                .tmr(rwStopIf)
            );
            tuc_timer #(.WIDTH(PULSE_W), .COUNT(PULSE_W'(MARKER_PULSE_CYC))) uMarkerPulse (
                .clk_sys(clk_sys),
                .reset(reset),
                .tmr(markerIf)
            );

            assign addrStart = startFromRest && (startUnit == uswS[gi]);
            assign addrRewind = rewindCmd && (rewindUnit == uswS[gi]);
            assign addrSkip = skipCmd && (skipUnit == uswS[gi]);
            assign unitReady[gi] = !unitSelect[gi] && !rewinding[gi] && !rwStopIf.busy
                                   && rdyS[gi];
            assign rwStopStart = rewinding[gi] && lmS[gi];
            assign rwStopIf.start = rwStopStart;
            assign eorEncounter = autoS[gi] && emS[gi] && !emPrev;
            assign eorDetect = eorEncounter && ((unitSelect[gi] && forwardRun) || rewinding[gi]);
            assign markerIf.start = (autoS[gi] && rwStopIf.done) || eorDetect;
            assign startAtLoadPoint[gi] = addrStart && unitReady[gi] && lmS[gi];

            assign nextLoadPoint = !autoS[gi] ? lmS[gi] :
                                   !lmS[gi] ? 1'b0 :
                                   (loadPoint[gi] || markerIf.busy);

            assign nextEndReel = !autoS[gi] ? (emS[gi] ? 1'b1 :
                                 ((!rdyS[gi] && !unitSelect[gi]) ? 1'b0 : endOfReel[gi])) :
                                 emS[gi] ? 1'b1 :
                                 (rewinding[gi] && emPrev) ? 1'b0 : endOfReel[gi];

            assign forwardActuate[gi] = unitSelect[gi] && forwardRun && !testS;
            assign reverseActuate[gi] = rewinding[gi] && !testS;

            assign densLowU[gi] = densS[gi][0] && unitSelect[gi];
            assign densMidU[gi] = densS[gi][1] && unitSelect[gi];
            assign densHighU[gi] = densS[gi][2] && unitSelect[gi];

            assign skipSel = (skipCode == SKIP_FILE_PROTECT) ? fpS[gi] :
                             (skipCode == SKIP_READY) ? unitReady[gi] :
                             (skipCode == SKIP_LOAD_POINT) ? loadPoint[gi] :
                             (skipCode == SKIP_END_REEL) ? endOfReel[gi] :
                             (skipCode == SKIP_DENS_LOW) ? densS[gi][0] :
                             (skipCode == SKIP_DENS_MID) ? densS[gi][1] :
                             (skipCode == SKIP_DENS_HIGH) ? densS[gi][2] : 1'b0;
            assign unitSkip[gi] = addrSkip && skipSel;

            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    emPrev <= 1'b0;
                    loadPoint[gi] <= 1'b0;
                    endOfReel[gi] <= 1'b0;
                    unitSelect[gi] <= 1'b0;
                    rewinding[gi] <= 1'b0;
                    loadPointInterrupt[gi] <= 1'b0;
                    endReelInterrupt[gi] <= 1'b0;
                end
                else
                begin
                    emPrev <= emS[gi];
                    loadPoint[gi] <= nextLoadPoint;
                    endOfReel[gi] <= nextEndReel;
                    loadPointInterrupt[gi] <= autoS[gi] && rwStopIf.done;
                    endReelInterrupt[gi] <= eorDetect;
                    if (addrStart && unitReady[gi])
                        unitSelect[gi] <= 1'b1;
                    else if (stopPulse)
                        unitSelect[gi] <= 1'b0;
                    if (addrRewind && unitReady[gi] && !lmS[gi])
                        rewinding[gi] <= 1'b1;
                    else if (rwStopStart)
                        rewinding[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Control unit outputs and skip line.
    // ----------------------------------------------------------------
    assign densityLowOut = |densLowU;
    assign densityMidOut = |densMidU;
    assign densityHighOut = |densHighU;

    assign skipAnswer = (|unitSkip)
                        || (skipCmd && (skipCode == SKIP_FILE_MARK) && fileMarkFlag)
                        || (skipCmd && (skipCode == SKIP_GAP) && (state == ST_GAP)
                            && !continued);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            skipTestLine <= 1'b0;
        else
            skipTestLine <= skipAnswer;
    end

    // ----------------------------------------------------------------
    // Motion sequencer.
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (startFromRest)
                    next_state = ST_START;
            ST_START:
                if (haltSignal)
                    next_state = ST_IDLE;
                else if (startDelayIf.done)
                    next_state = ST_RUN;
            ST_RUN:
                if (haltSignal)
                    next_state = ST_IDLE;
                else if (gapDetect)
                    next_state = ST_GAP;
            ST_GAP:
                if (continueCmd)
                    next_state = ST_RUN;
                else if (stopPulse)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Operation flags.
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            forwardRun <= 1'b0;
            bcdMode <= 1'b0;
            opReg <= OP_READ;
        end
        else if (startFromRest)
        begin
            forwardRun <= 1'b1;
            bcdMode <= startBcd;
            opReg <= startOp;
        end
        else if (stopPulse)
            forwardRun <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fileMarkFlag <= 1'b0;
        else if (startCmd || continueCmd)
            fileMarkFlag <= 1'b1;
        else if (notFileMark)
            fileMarkFlag <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            continued <= 1'b0;
        else if (continueCmd)
            continued <= 1'b1;
        else if (gapWindowIf.start)
            continued <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Write clock alignment and load-point inhibit.
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wclkPrev <= 1'b0;
            syncFlag <= 1'b0;
            writeClockDetect <= 1'b0;
        end
        else
        begin
            wclkPrev <= wclkS;
            writeClockDetect <= syncFlag && wclkRise && isWriteOp && forwardRun;
            if (startCmd || stopPulse)
                syncFlag <= 1'b0;
            else if (forwardRun && isWriteOp && !startDelayIf.busy && wclkRise)
                syncFlag <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            loadPointInhibit <= 1'b0;
        else if (startFromRest && (startOp == OP_READ) && (|startAtLoadPoint))
            loadPointInhibit <= 1'b1;
        else if (stopPulse)
            loadPointInhibit <= 1'b0;
    end

endmodule // tuc_top

// ==== test/tuc_top_sva.sv ====
`timescale 1ns/1ps
module tuc_top_sva
    import tuc_pkg::*;
#(
    parameter int NUM_UNITS = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic startCmd,
    input wire logic startBcd,
    input wire logic skipCmd,
    input wire tuc_pkg::tuc_skip_t skipCode,
    input wire logic testSwitch,
    input wire logic skipTestLine,
    input wire logic [NUM_UNITS-1:0] unitSelect,
    input wire logic [NUM_UNITS-1:0] forwardActuate,
    input wire logic densityLowOut,
    input wire logic densityHighOut,
    input wire logic forwardRun,
    input wire logic bcdMode,
    input wire logic oddParity,
    input wire logic haltSignal,
    input wire logic minCycleBusy,
    input wire logic fileMarkFlag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_idle; !$past(skipCmd) |-> !skipTestLine; endproperty
    a_idle: assert property (p_idle) else $error("skip line raised without a test");
    property p_dens; unitSelect == '0 |-> !densityLowOut && !densityHighOut; endproperty
    a_dens: assert property (p_dens) else $error("density shown with no unit selected");
    property p_fwd; startCmd && !forwardRun |=> forwardRun; endproperty
    a_fwd: assert property (p_fwd) else $error("start did not set forward run");
    property p_bcd; startCmd && startBcd && !forwardRun |=> bcdMode; endproperty
    a_bcd: assert property (p_bcd) else $error("start did not set bcd mode");
    property p_par; oddParity == !bcdMode; endproperty
    a_par: assert property (p_par) else $error("parity sense wrong");
    property p_halt; minCycleBusy |-> !haltSignal; endproperty
    a_halt: assert property (p_halt) else $error("halt during minimum cycle");
    property p_cyc; startCmd && !forwardRun |-> ##[1:2] minCycleBusy; endproperty
    a_cyc: assert property (p_cyc) else $error("minimum cycle timer not started");
    property p_test; testSwitch [*3] |-> forwardActuate == '0; endproperty
    a_test: assert property (p_test) else $error("motion while test switch on");
    property p_fm; startCmd |=> fileMarkFlag; endproperty
    a_fm: assert property (p_fm) else $error("start did not set file mark flag");
    property p_fmt; skipCmd && skipCode == SKIP_FILE_MARK |=> skipTestLine == $past(fileMarkFlag); endproperty
    a_fmt: assert property (p_fmt) else $error("file mark test answer wrong");
endmodule // tuc_top_sva

bind tuc_top tuc_top_sva #(.NUM_UNITS(NUM_UNITS)) u_sva (.*);

// ==== test/tuc_host.sv ====
`timescale 1ns/1ps
module tuc_host
    import tuc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic skipTestLine,
    output logic startCmd = 1'b0,
    output tuc_pkg::tuc_op_t startOp = OP_WRITE,
    output logic startBcd = 1'b0,
    output logic [tuc_pkg::UNIT_W-1:0] startUnit = '0,
    output logic rewindCmd = 1'b0,
    output logic [tuc_pkg::UNIT_W-1:0] rewindUnit = '0,
    output logic haltRequest = 1'b0,
    output logic continueCmd = 1'b0,
    output logic skipCmd = 1'b0,
    output tuc_pkg::tuc_skip_t skipCode = '0,
    output logic [tuc_pkg::UNIT_W-1:0] skipUnit = '0
);
    task automatic start(input tuc_op_t op, input logic bcd, input logic [UNIT_W-1:0] u);
        @(posedge clk_sys);
        startCmd <= 1'b1;
        startOp <= op;
        startBcd <= bcd;
        startUnit <= u;
        @(posedge clk_sys);
        startCmd <= 1'b0;
        startOp <= tuc_op_t'(~op);
        startBcd <= ~bcd;
        startUnit <= ~u;
    endtask
    task automatic skip(input tuc_skip_t c, input logic [UNIT_W-1:0] u, output logic r);
        @(posedge clk_sys);
        skipCmd <= 1'b1;
        skipCode <= c;
        skipUnit <= u;
        @(posedge clk_sys);
        skipCmd <= 1'b0;
        skipCode <= ~c;
        skipUnit <= ~u;
        #1 r = skipTestLine;
    endtask
    task automatic cont();
        @(posedge clk_sys);
        continueCmd <= 1'b1;
        @(posedge clk_sys);
        continueCmd <= 1'b0;
    endtask
    task automatic rewind(input logic [UNIT_W-1:0] u);
        @(posedge clk_sys);
        rewindCmd <= 1'b1;
        rewindUnit <= u;
        @(posedge clk_sys);
        rewindCmd <= 1'b0;
    endtask
    task automatic halt(input logic v);
        @(posedge clk_sys);
        haltRequest <= v;
    endtask
endmodule // tuc_host

// ==== test/tuc_top_tb.sv ====
`timescale 1ns/1ps
module tuc_top_tb;
    import tuc_pkg::*;
    localparam int N = 2;
    localparam int SD = 20;
    localparam int MC = 50;
    localparam int GW = 40;
    logic clk_sys = 1'b0, reset = 1'b1, testSwitch = 1'b0, writeCharClock = 1'b0;
    logic gapDetect = 1'b0, notFileMark = 1'b0;
    logic [N-1:0] loadMarker = 2'h1, endMarker = 2'h2, transportReady = 2'h3, autoMode = 2'h0, fileProtect = 2'h1;
    logic [N-1:0][UNIT_W-1:0] unitSwitch = {3'h2, 3'h5};
    logic [N-1:0][2:0] densitySwitch = {3'h4, 3'h1};
    logic [N-1:0] loadPoint, endOfReel, loadPointInterrupt, endReelInterrupt, unitSelect, rewinding;
    logic [N-1:0] unitReady, forwardActuate, reverseActuate;
    logic skipTestLine, densityLowOut, densityMidOut, densityHighOut, forwardRun, bcdMode, oddParity;
    logic writeEnable, startDelayBusy, minCycleBusy, haltSignal, syncFlag, writeClockDetect, loadPointInhibit;
    logic fileMarkFlag, startCmd, startBcd, rewindCmd, haltRequest, continueCmd, skipCmd;
    tuc_op_t startOp;
    tuc_skip_t skipCode;
    logic [UNIT_W-1:0] startUnit, rewindUnit, skipUnit;
    int err_count = 0, n_checks = 0, cyc = 0;
    tuc_top #(.NUM_UNITS(N), .START_DELAY_CYCLES(SD), .MIN_CYCLE_CYCLES(MC), .REWIND_STOP_CYCLES(30),
        .GAP_WINDOW_CYCLES(GW)) DUT (.*);
    tuc_host host (.*);
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        writeCharClock <= cyc[2];
        if (cyc == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic sk(input tuc_skip_t c, input logic [2:0] u, input logic e, input string nm);
        logic r;
        host.skip(c, u, r);
        check(nm, r, e);
    endtask
    task automatic pulse_gap();
        @(posedge clk_sys);
        gapDetect <= 1'b1;
        @(posedge clk_sys);
        gapDetect <= 1'b0;
    endtask
    task automatic wait_stop(input int lim);
        for (int i = 0; i < lim && forwardRun; i++) @(posedge clk_sys);
        #1;
    endtask
    initial
    begin
        int t0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("lpflag", loadPoint, 2'h1);
        sk(SKIP_FILE_PROTECT, 3'h5, 1'b1, "fp0");
        sk(SKIP_FILE_PROTECT, 3'h2, 1'b0, "fp1");
        sk(SKIP_READY, 3'h2, 1'b1, "rdy1");
        sk(SKIP_LOAD_POINT, 3'h5, 1'b1, "lp0");
        sk(SKIP_LOAD_POINT, 3'h2, 1'b0, "lp1");
        sk(SKIP_END_REEL, 3'h2, 1'b1, "eor1");
        sk(SKIP_DENS_LOW, 3'h5, 1'b1, "dl0");
        sk(SKIP_DENS_MID, 3'h5, 1'b0, "dm0");
        sk(SKIP_DENS_HIGH, 3'h2, 1'b1, "dh1");
        sk(SKIP_DENS_HIGH, 3'h7, 1'b0, "none");
        endMarker <= 2'h0;
        transportReady <= 2'h1;
        repeat (4) @(posedge clk_sys);
        sk(SKIP_END_REEL, 3'h2, 1'b0, "eorclr");
        transportReady <= 2'h3;
        $display("status tests done");
        t0 = cyc;
        host.start(OP_READ, 1'b1, 3'h5);
        @(posedge clk_sys);
        #1;
        check("sel", {forwardRun, unitSelect}, 3'h5);
        check("bcd", {bcdMode, oddParity}, 2'h2);
        check("dens", {densityHighOut, densityMidOut, densityLowOut}, 3'h1);
        check("lpi", loadPointInhibit, 1'b1);
        check("fwdact", forwardActuate, 2'h1);
        check("sdb", startDelayBusy, 1'b1);
        sk(SKIP_READY, 3'h5, 1'b0, "rdysel");
        sk(SKIP_FILE_MARK, 3'h0, 1'b1, "fm");
        host.halt(1'b1);
        wait_stop(200);
        check("mincyc", {forwardRun, (cyc - t0) >= MC}, 2'h1);
        host.halt(1'b0);
        $display("read start done");
        t0 = cyc;
        host.start(OP_WRITE, 1'b0, 3'h2);
        @(posedge clk_sys);
        #1;
        check("wen", {writeEnable, unitSelect}, 3'h6);
        check("dens2", {densityHighOut, densityMidOut, densityLowOut}, 3'h4);
        for (int i = 0; i < 100 && startDelayBusy; i++) @(posedge clk_sys);
        #1;
        check("sdlen", (cyc - t0) inside {[SD:SD + 4]}, 1'b1);
        for (int i = 0; i < 30 && !syncFlag; i++) @(posedge clk_sys);
        #1;
        check("sync", syncFlag, 1'b1);
        for (int i = 0; i < 30 && !writeClockDetect; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        check("wcd", writeClockDetect, 1'b1);
        pulse_gap();
        sk(SKIP_GAP, 3'h0, 1'b1, "gap");
        host.cont();
        sk(SKIP_GAP, 3'h0, 1'b0, "gapcont");
        @(posedge clk_sys);
        notFileMark <= 1'b1;
        @(posedge clk_sys);
        notFileMark <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("fmclr", fileMarkFlag, 1'b0);
        repeat (MC) @(posedge clk_sys);
        pulse_gap();
        t0 = cyc;
        wait_stop(300);
        check("winstop", {forwardRun, (cyc - t0) >= GW - 2}, 2'h1);
        $display("write and gap done");
        autoMode <= 2'h2;
        host.rewind(3'h2);
        #1;
        check("rw", {rewinding, reverseActuate}, 4'ha);
        loadMarker <= 2'h3;
        repeat (10) @(posedge clk_sys);
        #1;
        check("lpwait", loadPoint, 2'h1);
        check("rwrdy", {rewinding, unitReady}, 4'h1);
        for (int i = 0; i < 60 && !loadPointInterrupt[1]; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        check("lpint", loadPointInterrupt, 2'h2);
        @(posedge clk_sys);
        #1;
        check("lpauto", loadPoint, 2'h3);
        $display("rewind done");
        testSwitch <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host.start(OP_SCAN, 1'b0, 3'h5);
        @(posedge clk_sys);
        #1;
        check("act", forwardActuate, 2'h0);
        host.halt(1'b1);
        wait_stop(300);
        host.halt(1'b0);
        $display("test switch done");
        stop_test();
    end
endmodule // tuc_top_tb
